/* ebwrh_ctrl.sv */
// bus cycle controller: software waits, ready stretch and bus hold
`timescale 1ns/100ps
module ebwrh_ctrl
  import ebwrh_pkg::*;
#(
  parameter int AW = 20,
  parameter int DW = 16
)(
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          clk_en,
  input  wire logic [1:0]    proc_mode,
  input  wire logic          global_wait_bit,
  input  wire logic [3:0]    area_wait_bits,
  input  wire logic [1:0]    mux_bus_sel,
  input  wire logic          acc_req,
  input  wire logic [1:0]    acc_area,
  input  wire logic          acc_write,
  input  wire logic [1:0]    acc_be,
  input  wire logic [AW-1:0] acc_addr,
  input  wire logic [DW-1:0] acc_wdata,
  input  wire logic [DW-1:0] data_in,
  input  wire logic          ready_n,
  input  wire logic          hold_req_n,
  output logic               acc_busy,
  output logic               acc_done,
  output logic [DW-1:0]      acc_rdata,
  output logic [AW-1:0]      addr_out,
  output logic               addr_oe,
  output logic [DW-1:0]      data_out,
  output logic               data_oe,
  output logic               rd_n,
  output logic               low_byte_write_strobe_n,
  output logic               high_byte_write_strobe_n,
  output logic               upper_byte_enable_n,
  output logic [3:0]         area_select_outs_n,
  output logic               strobe_oe,
  output logic               ale_out,
  output logic               bclk_out,
  output logic               bus_grant_out_n
);
  typedef struct packed {
    ebwrh_st_t     st;
    logic          phase;
    logic [1:0]    left;
    logic          waited;
    logic          is_mux;
    logic          wr;
    logic [DW-1:0] wdata;
    logic          addr_en;
    logic          flt;
    logic          busy;
    logic          done;
    logic [DW-1:0] rdata;
    logic [AW-1:0] addr;
    logic          addr_oe;
    logic [DW-1:0] dout;
    logic          data_oe;
    logic          rd_n;
    logic          lo_wr_n;
    logic          hi_wr_n;
    logic          ube_n;
    logic [3:0]    cs_n;
    logic          strobe_oe;
    logic          ale;
    logic          grant_n;
  } ebwrh_state_t;

  ebwrh_state_t cur_ff;
  ebwrh_state_t nxt_cur;
  logic         fall;
  logic         rise;
  logic         hold_ok;
  logic         wsel;
  logic         msel;

  function automatic logic ebwrh_is_mux(input logic [1:0] sel, input logic [1:0] area);
    ebwrh_is_mux = (sel == MUX_ALL) || (sel == MUX_AREA2 && area == AREA2) ||
                   (sel == MUX_AREA1 && area == AREA1);
  endfunction : ebwrh_is_mux

  assign fall    = clk_en && cur_ff.phase;
  assign rise    = clk_en && !cur_ff.phase;
  assign hold_ok = (proc_mode == MODE_EXPAND) || (proc_mode == MODE_MICRO);
  assign wsel    = global_wait_bit || area_wait_bits[acc_area];
  assign msel    = ebwrh_is_mux(mux_bus_sel, acc_area);

  always_comb
  begin
    nxt_cur      = cur_ff;
    nxt_cur.done = 1'b0;
    if (clk_en)
    begin
      nxt_cur.phase = !cur_ff.phase;
      if (rise)
        nxt_cur.ale = 1'b0;
    end
    unique case (cur_ff.st)
      ST_IDLE:
      begin
        if (fall && !hold_req_n && hold_ok)
        begin
          nxt_cur.flt = 1'b1;
          nxt_cur.st  = ST_FLOAT;
        end
        else if (fall && acc_req)
        begin
          nxt_cur.st      = ST_CYC;
          nxt_cur.busy    = 1'b1;
          nxt_cur.waited  = wsel;
          nxt_cur.is_mux  = msel;
          nxt_cur.wr      = acc_write;
          nxt_cur.wdata   = acc_wdata;
          nxt_cur.left    = !wsel ? CYC_NOWAIT : (msel ? CYC_MUXWAIT : CYC_SEPWAIT);
          nxt_cur.addr    = acc_addr;
          nxt_cur.addr_en = 1'b1;
          nxt_cur.ale     = 1'b1;
          nxt_cur.cs_n    = ~(4'h1 << acc_area);
          nxt_cur.ube_n   = !acc_be[1];
          nxt_cur.rd_n    = acc_write;
          nxt_cur.lo_wr_n = !(acc_write && acc_be[0]);
          nxt_cur.hi_wr_n = !(acc_write && acc_be[1]);
          nxt_cur.dout    = (msel && wsel) ? acc_addr[DW-1:0] : acc_wdata;
          nxt_cur.data_oe = acc_write || (msel && wsel);
        end
      end
      ST_CYC:
      begin
        if (fall && !(cur_ff.waited && !ready_n))
        begin
          nxt_cur.left = cur_ff.left - 2'h1;
          if (cur_ff.is_mux && cur_ff.left == CYC_MUXWAIT)
          begin
            nxt_cur.dout    = cur_ff.wdata;
            nxt_cur.data_oe = cur_ff.wr;
          end
          if (cur_ff.left == CYC_NOWAIT)
          begin
            nxt_cur.st      = ST_IDLE;
            nxt_cur.busy    = 1'b0;
            nxt_cur.done    = 1'b1;
            nxt_cur.rdata   = cur_ff.wr ? cur_ff.rdata : data_in;
            nxt_cur.rd_n    = 1'b1;
            nxt_cur.lo_wr_n = 1'b1;
            nxt_cur.hi_wr_n = 1'b1;
            nxt_cur.ube_n   = 1'b1;
            nxt_cur.cs_n    = 4'hF;
            nxt_cur.data_oe = 1'b0;
          end
        end
      end
      ST_FLOAT:
      begin
        if (rise)
        begin
          nxt_cur.grant_n = 1'b0;
          nxt_cur.st      = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (rise && hold_req_n)
        begin
          nxt_cur.grant_n = 1'b1;
          nxt_cur.st      = ST_REL;
        end
      end
      ST_REL:
      begin
        if (fall)
        begin
          nxt_cur.flt = 1'b0;
          nxt_cur.st  = ST_IDLE;
        end
      end
    endcase
    if (nxt_cur.flt)
      nxt_cur.ale = nxt_cur.phase;
    nxt_cur.addr_oe   = nxt_cur.addr_en && !nxt_cur.flt;
    nxt_cur.strobe_oe = !nxt_cur.flt;
    if (nxt_cur.flt)
      nxt_cur.data_oe = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur_ff       <= '0;
      cur_ff.st    <= ST_IDLE;
      cur_ff.rd_n  <= 1'b1;
      cur_ff.lo_wr_n <= 1'b1;
      cur_ff.hi_wr_n <= 1'b1;
      cur_ff.ube_n <= 1'b1;
      cur_ff.cs_n  <= 4'hF;
      cur_ff.strobe_oe <= 1'b1;
      cur_ff.grant_n   <= 1'b1;
    end
    else
      cur_ff <= nxt_cur;
  end

  assign acc_busy                 = cur_ff.busy;
  assign acc_done                 = cur_ff.done;
  assign acc_rdata                = cur_ff.rdata;
  assign addr_out                 = cur_ff.addr;
  assign addr_oe                  = cur_ff.addr_oe;
  assign data_out                 = cur_ff.dout;
  assign data_oe                  = cur_ff.data_oe;
  assign rd_n                     = cur_ff.rd_n;
  assign low_byte_write_strobe_n  = cur_ff.lo_wr_n;
  assign high_byte_write_strobe_n = cur_ff.hi_wr_n;
  assign upper_byte_enable_n      = cur_ff.ube_n;
  assign area_select_outs_n       = cur_ff.cs_n;
  assign strobe_oe                = cur_ff.strobe_oe;
  assign ale_out                  = cur_ff.ale;
  assign bclk_out                 = cur_ff.phase;
  assign bus_grant_out_n          = cur_ff.grant_n;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic start;
  assign start = cur_ff.st == ST_IDLE && nxt_cur.st == ST_CYC;

  property p_sep_wait;
    start && wsel && !msel |=> cur_ff.left == 2'h2;
  endproperty
  a_sep_wait: assert property (p_sep_wait) else $error("separate wait not two");
  property p_mux_wait;
    start && wsel && msel |=> cur_ff.left == 2'h3;
  endproperty
  a_mux_wait: assert property (p_mux_wait) else $error("mux wait not three");
  property p_global;
    start && global_wait_bit |=> cur_ff.waited;
  endproperty
  a_global: assert property (p_global) else $error("global wait ignored");
  property p_area;
    start && !global_wait_bit |=> cur_ff.waited == $past(wsel);
  endproperty
  a_area: assert property (p_area) else $error("area wait bit ignored");
  property p_noready;
    fall && cur_ff.st == ST_CYC && !cur_ff.waited |=> cur_ff.st == ST_IDLE;
  endproperty
  a_noready: assert property (p_noready) else $error("unwaited cycle stretched");
  property p_stall;
    fall && cur_ff.st == ST_CYC && cur_ff.waited && !ready_n
      |=> $stable(cur_ff.left) && $stable(addr_out) && $stable(rd_n) && $stable(data_out);
  endproperty
  a_stall: assert property (p_stall) else $error("bus moved while ready low");
  property p_mode;
    cur_ff.st == ST_IDLE && !hold_ok |=> !cur_ff.flt;
  endproperty
  a_mode: assert property (p_mode) else $error("hold taken in wrong mode");
  property p_grant;
    $fell(bus_grant_out_n) |-> !$past(strobe_oe) && bclk_out;
  endproperty
  a_grant: assert property (p_grant) else $error("grant before float");
  property p_release;
    $rose(bus_grant_out_n) |-> ##[1:2] strobe_oe;
  endproperty
  a_release: assert property (p_release) else $error("buses not restored");
  property p_nomid;
    $fell(strobe_oe) |-> $past(cur_ff.st) == ST_IDLE;
  endproperty
  a_nomid: assert property (p_nomid) else $error("released mid cycle");
  property p_float;
    !bus_grant_out_n |-> !addr_oe && !data_oe && !strobe_oe;
  endproperty
  a_float: assert property (p_float) else $error("pin driven in hold");
  property p_ale;
    !bus_grant_out_n |-> ale_out == bclk_out;
  endproperty
  a_ale: assert property (p_ale) else $error("latch strobe not bus clock");

  c_wait: cover property (start && wsel ##[1:20] acc_done);
  c_stall: cover property (fall && cur_ff.st == ST_CYC && cur_ff.waited && !ready_n);
  c_hold: cover property ($fell(bus_grant_out_n) ##[1:40] $rose(bus_grant_out_n));
endmodule : ebwrh_ctrl

/* ebwrh_ctrl_bench.sv */
// self-checking bench for the bus wait, ready and hold controller
`timescale 1ns/100ps
module ebwrh_ctrl_bench
  import ebwrh_pkg::*;
;
  logic        sys_clk, rstn, clk_en, global_wait_bit, acc_req, acc_write, hold_go;
  logic        acc_busy, acc_done, addr_oe, data_oe, rd_n, strobe_oe, ale_out, bclk_out;
  logic        ready_n, hold_req_n, bus_grant_out_n, upper_byte_enable_n;
  logic        low_byte_write_strobe_n, high_byte_write_strobe_n;
  logic [1:0]  proc_mode, mux_bus_sel, acc_area, acc_be;
  logic [3:0]  area_wait_bits, area_select_outs_n, stretch;
  logic [19:0] acc_addr, addr_out;
  logic [15:0] acc_wdata, data_in, acc_rdata, data_out;
  int          miscompares = 0, cmp_count = 0;
  ebwrh_ctrl DUT (.*);
  ebwrh_far_model far (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic await(ref logic s, input logic v);
    for (int n = 0; s !== v; n++)
    begin
      tick(1);
      if (n == 200)
      begin
        miscompares++;
        conclude();
      end
    end
  endtask : await
  task automatic acc(input logic [10:0] cfg, input logic [1:0] ar, input logic wr, input int nb);
    int n;
    {global_wait_bit, area_wait_bits, mux_bus_sel, stretch} = cfg;
    {acc_area, acc_write, acc_addr, acc_wdata} = {ar, wr, ar, 18'h05A3C, 16'h3C5A};
    acc_req = 1'b1;
    await(acc_busy, 1'b1);
    chk({addr_out, area_select_outs_n}, {ar, 18'h05A3C, ~(4'h1 << ar)});
    chk({low_byte_write_strobe_n, high_byte_write_strobe_n, rd_n}, {!wr, !wr, wr});
    for (n = 0; acc_done !== 1'b1 && n < 40; n++)
      tick(1);
    acc_req = 1'b0;
    chk(n, 2 * nb);
    if (!wr)
      chk(acc_rdata, 16'(~acc_addr[15:0]));
    tick(1);
  endtask : acc
  task automatic t_waits;
    acc(11'h0A0, AREA1, 1'b0, 3);
    acc(11'h0A0, AREA2, 1'b1, 1);
    acc(11'h090, AREA1, 1'b1, 2);
    acc(11'h490, AREA2, 1'b0, 3);
    acc(11'h490, 2'h3, 1'b0, 2);
    acc(11'h4B0, 2'h0, 1'b1, 3);
    acc(11'h482, AREA1, 1'b0, 4);
    acc(11'h4B1, AREA2, 1'b1, 4);
    acc(11'h032, AREA1, 1'b0, 1);
    acc(11'h480, AREA2, 1'b0, 2);
  endtask : t_waits
  task automatic t_hold_modes;
    for (int i = 0; i < 4; i += 2)
    begin
      {proc_mode, hold_go} = {2'(i), 1'b1};
      tick(10);
      chk({bus_grant_out_n, strobe_oe}, 2'h3);
      hold_go = 1'b0;
      tick(4);
    end
  endtask : t_hold_modes
  task automatic t_hold(input logic mid, input logic [1:0] mode);
    {proc_mode, acc_req} = {mode, mid};
    await(acc_busy, mid);
    hold_go = 1'b1;
    for (int n = 0; mid && acc_done !== 1'b1 && n < 40; n++)
    begin
      chk({bus_grant_out_n, strobe_oe}, 2'h3);
      tick(1);
    end
    if (mid)
      acc_req = 1'b0;
    await(strobe_oe, 1'b0);
    chk({bus_grant_out_n, addr_oe, data_oe}, 3'h4);
    tick(1);
    chk({bus_grant_out_n, ale_out}, 2'h1);
    tick(1);
    chk({ale_out, strobe_oe, addr_oe, data_oe}, 4'h0);
    hold_go = 1'b0;
    await(bus_grant_out_n, 1'b1);
    chk(strobe_oe, 1'b0);
    tick(1);
    chk({strobe_oe, addr_oe}, 2'h3);
  endtask : t_hold
  initial
  begin
    {rstn, clk_en, global_wait_bit, acc_req, acc_write, hold_go} = 6'h10;
    {proc_mode, mux_bus_sel, acc_area, acc_be, area_wait_bits, stretch} = {MODE_EXPAND, 14'h0300};
    tick(6);
    rstn = 1'b1;
    t_waits();
    t_hold_modes();
    t_hold(1'b0, MODE_MICRO);
    t_hold(1'b1, MODE_EXPAND);
    conclude();
  end
endmodule : ebwrh_ctrl_bench

/* ebwrh_far_model.sv */
// far side model: read data (inverted address, writes not stored), ready stretch logic and second bus master
`timescale 1ns/100ps
module ebwrh_far_model (
  input  wire logic        sys_clk,
  input  wire logic        bclk_out,
  input  wire logic        rd_n,
  input  wire logic [3:0]  area_select_outs_n,
  input  wire logic [19:0] addr_out,
  input  wire logic [3:0]  stretch,
  input  wire logic        hold_go,
  output logic      [15:0] data_in,
  output logic             ready_n,
  output logic             hold_req_n
);
  logic [3:0] cnt_ff;
  initial {cnt_ff, ready_n, hold_req_n, data_in} = {4'h0, 2'h3, 16'h0};
  always @(posedge sys_clk)
  begin
    data_in <= #1 (!rd_n && area_select_outs_n != 4'hF) ? ~addr_out[15:0] : ~data_in;
    hold_req_n <= #1 !hold_go;
    if (area_select_outs_n == 4'hF)
      cnt_ff <= 4'h0;
    else if (!bclk_out && cnt_ff < stretch)
      cnt_ff <= cnt_ff + 4'h1;
    if (area_select_outs_n == 4'hF || !bclk_out)
      ready_n <= #1 area_select_outs_n == 4'hF || cnt_ff >= stretch;
  end
endmodule : ebwrh_far_model

/* ebwrh_pkg.sv */
// shared constants and types for the external bus wait, ready and hold controller
package ebwrh_pkg;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_EXPAND = 2'h1;
  localparam logic [1:0] MODE_MICRO  = 2'h3;
  localparam logic [1:0] MUX_NONE    = 2'h0;
  localparam logic [1:0] MUX_AREA2   = 2'h1;
  localparam logic [1:0] MUX_AREA1   = 2'h2;
  localparam logic [1:0] MUX_ALL     = 2'h3;
  localparam logic [1:0] AREA1       = 2'h1;
  localparam logic [1:0] AREA2       = 2'h2;
  localparam logic [1:0] CYC_NOWAIT  = 2'h1;
  localparam logic [1:0] CYC_SEPWAIT = 2'h2;
  localparam logic [1:0] CYC_MUXWAIT = 2'h3;
  typedef enum logic [2:0] {ST_IDLE, ST_CYC, ST_FLOAT, ST_HOLD, ST_REL} ebwrh_st_t;
endpackage : ebwrh_pkg
